// ===== shared/fpld_defines.svh
// Constants for the front panel lamp driver
`ifndef FPLD_DEFINES_SVH
`define FPLD_DEFINES_SVH
`define FPLD_CLK_HZ       50000000
`define FPLD_HOLD_MS      100
`define FPLD_HOLD_CYCLES  ((`FPLD_CLK_HZ / 1000) * `FPLD_HOLD_MS)
`define FPLD_NUM_REQ      10
`define FPLD_NUM_DRIVES   15
`define FPLD_MAP_RESET    40'h9876543210
`endif

// ===== shared/fpld_pkg.sv
// Types for the front panel lamp driver
package fpld_pkg;
  // Open-drain cathode pin: level out and enable
  typedef struct packed {
    logic [14:0] level;
    logic [14:0] oe;
  } fpld_pins_t;
endpackage

// ===== src/fpld_top.sv
// Front panel lamp driver: request mapping, stretching, open-drain drive
`timescale 1ns/1ps
`include "fpld_defines.svh"
module fpld_top
  import fpld_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = `FPLD_HOLD_CYCLES,
  // Drive index per request, 4 bits each; 15 means unused
  parameter logic [39:0] REQ_MAP     = `FPLD_MAP_RESET
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [4:0]  base_function_lamp_request_in,
  input  wire logic [4:0]  topology_lamp_request_in,
  input  wire logic        power_good_in,
  output logic             lamp_1l_green_n_out,
  output logic [14:0]      lamp_drive_level_out,
  output logic [14:0]      lamp_drive_oe_out
);
  // Drive order: 0 1R g, 1 2L g, 2 2R g, then 3L..5R red/green pairs
  // 3 3L g, 4 3L r, 5 3R g, 6 3R r, 7 4L g, 8 4L r, 9 4R g,
  // 10 4R r, 11 5L g, 12 5L r, 13 5R g, 14 5R r
  // Red pins only exist for 3-5; rows 1-2 carry no red drive

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  typedef struct packed {
    logic [9:0]            req_s1;
    logic [9:0]            req_s2;
    logic                  pg_s1;
    logic                  pg_s2;
    logic [14:0][CW-1:0]   hold;
    // Level and enable registered so the pins come straight off flops
    fpld_pins_t            pins;
    logic                  pg_lamp_n;
  } fpld_state_t;

  fpld_state_t state_reg;
  fpld_state_t state_next;
  logic [14:0] want;

  // Map one request index to its drive index
  function automatic logic [3:0] map_of(input int unsigned i);
    map_of = REQ_MAP[i*4 +: 4];
  endfunction

  // Every drive that some request can reach; the rest must stay dark
  function automatic logic [14:0] map_mask();
    logic [14:0] m;
    m = 15'h0000;
    for (int unsigned i = 0; i < `FPLD_NUM_REQ; i++) begin
      if (map_of(i) != 4'hf) begin
        m[map_of(i)] = 1'h1;
      end
    end
    return m;
  endfunction

  // Mapping lives here, not with the requesters
  always_comb begin
    want = 15'h0000;
    for (int unsigned i = 0; i < `FPLD_NUM_REQ; i++) begin
      if (state_reg.req_s2[i] && map_of(i) != 4'hf) begin
        want[map_of(i)] = 1'b1;
      end
    end
  end

  // Synchronise pins, stretch each drive with a restartable counter
  always_comb begin
    state_next = state_reg;
    state_next.req_s1 = {topology_lamp_request_in,
                         base_function_lamp_request_in};
    state_next.req_s2 = state_reg.req_s1;
    state_next.pg_s1 = power_good_in;
    state_next.pg_s2 = state_reg.pg_s1;
    state_next.pg_lamp_n = ~state_reg.pg_s2;
    // Level stays low; only the enable decides whether a colour sinks
    state_next.pins.level = 15'h0000;
    // A fresh request reloads the full count even mid-hold, so a
    // chatty source keeps the lamp on instead of letting it blink
    for (int d = 0; d < `FPLD_NUM_DRIVES; d++) begin
      if (want[d]) begin
        state_next.hold[d] = CW'(HOLD_CYCLES);
        state_next.pins.oe[d] = 1'h1;
      end else if (state_reg.hold[d] > CW'(1)) begin
        state_next.hold[d] = state_reg.hold[d] - CW'(1);
        state_next.pins.oe[d] = 1'h1;
      end else begin
        state_next.hold[d] = '0;
        state_next.pins.oe[d] = 1'h0;
      end
    end
  end

  // Synchronous reset: all lamps dark
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '{default: '0, pg_lamp_n: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  // Open-drain: level always 0, enable pulls the cathode low
  // Never driving high avoids the noisy fast turn-off edge
  assign lamp_drive_level_out = state_reg.pins.level;
  assign lamp_drive_oe_out = state_reg.pins.oe;
  assign lamp_1l_green_n_out = state_reg.pg_lamp_n;

  // Drive 0, once lit by a request, stays on for at least the next 8 edges
  a_hold_after_req: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    want[0] |=> lamp_drive_oe_out[0] [*8])
    else $error("lamp dropped before hold expired");

  a_restart_hold: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    want[3] |=> state_reg.hold[3] == CW'(HOLD_CYCLES))
    else $error("hold counter not restarted");

  a_never_high: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    lamp_drive_level_out == 15'h0000)
    else $error("lamp pin driven high");

  a_dark_when_idle: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (state_reg.hold[5] == '0 && !want[5]) |=> !lamp_drive_oe_out[5])
    else $error("lamp lit without request or hold");

  a_pg_lamp: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    $rose(state_reg.pg_s2) |=> !lamp_1l_green_n_out)
    else $error("power-good lamp not lit");

  a_req_maps: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (state_reg.req_s2[0] && map_of(0) != 4'hf) |=>
      lamp_drive_oe_out[map_of(0)])
    else $error("mapped request did not light lamp");

  a_sync_delay: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    base_function_lamp_request_in[1] ##1 1'b1 |=> state_reg.req_s2[1])
    else $error("request not synchronised in two stages");

  a_topo_path: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    topology_lamp_request_in[4] |=> state_reg.req_s1[9])
    else $error("topology request lost");

  // Power-good lamp tracks the pin three edges late
  a_pg_on_path: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    power_good_in ##2 1'b1 |=> !lamp_1l_green_n_out)
    else $error("power-good lamp late to light");

  a_pg_off_path: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    !power_good_in ##2 1'b1 |=> lamp_1l_green_n_out)
    else $error("power-good lamp late to go dark");

  // Drives that no request reaches must never light
  a_unmapped_dark: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (lamp_drive_oe_out & ~map_mask()) == 15'h0000)
    else $error("unmapped lamp lit");

  // Per-drive chain: load on request, count down by one, fall only at
  // the end of the count; together these pin the minimum on-time
  // without a second timer that would cost fabric in every drive
  for (genvar gd = 0; gd < `FPLD_NUM_DRIVES; gd++) begin : g_drive_chk
    // A colour only lights after its synchronised request
    a_rise_on_req: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      $rose(lamp_drive_oe_out[gd]) |-> $past(want[gd]))
      else $error("lamp lit without a request");

    // Any request, even mid-hold, reloads the whole count
    a_load_full: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      want[gd] |=> (state_reg.hold[gd] == CW'(HOLD_CYCLES) &&
                    lamp_drive_oe_out[gd]))
      else $error("hold not loaded on request");

    // Without a request the count drops by exactly one per edge
    a_count_down: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      (lamp_drive_oe_out[gd] && !want[gd] &&
       state_reg.hold[gd] > CW'(1)) |=>
        (state_reg.hold[gd] == $past(state_reg.hold[gd]) - CW'(1) &&
         lamp_drive_oe_out[gd]))
      else $error("hold did not count down while lit");

    // Turn-off only once the last count has been spent
    a_fall_at_end: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      $fell(lamp_drive_oe_out[gd]) |->
        ($past(state_reg.hold[gd]) == CW'(1) && !$past(want[gd])))
      else $error("lamp dropped before its count ran out");

    // A lit colour always has some hold left
    a_lit_has_hold: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      lamp_drive_oe_out[gd] |-> state_reg.hold[gd] != '0)
      else $error("lamp lit with no hold left");

    // Count never runs above its load value
    a_hold_bound: assert property (@(posedge ref_clk_in)
      disable iff (!rst_n_in)
      state_reg.hold[gd] <= CW'(HOLD_CYCLES))
      else $error("hold count above its load value");
  end
endmodule

// ===== test/fpld_lamp_model.sv
// Front panel lamps with anode pull-ups
`timescale 1ns/1ps
module fpld_lamp_model (
  input  wire logic [14:0] level_in,
  input  wire logic [14:0] oe_in,
  output logic      [14:0] lit_out
);
  // Pull-up keeps the cathode dark unless the pin sinks low
  assign lit_out = oe_in & ~level_in;
endmodule

// ===== test/tb_fpld_top.sv
// Self-checking bench for the front panel lamp driver
`timescale 1ns/1ps
module tb_fpld_top;
  import fpld_pkg::*;
  localparam int HOLD = 20;
  logic        clk = 0;
  logic        rst_n = 0;
  logic        pg = 0;
  logic [9:0]  req = '0;
  logic [14:0] lvl;
  logic [14:0] oe;
  logic [14:0] lit;
  logic        lamp_n;
  int          failures = 0;
  int          n_checks = 0;
  int          cnt = 0;
  int          idx = 0;
  int          exp_q[$];
  // Short hold keeps the run brief
  initial forever #10 clk = ~clk;
  fpld_top #(.HOLD_CYCLES(HOLD)) dut (.ref_clk_in(clk), .rst_n_in(rst_n),
    .base_function_lamp_request_in(req[4:0]),
    .topology_lamp_request_in(req[9:5]), .power_good_in(pg),
    .lamp_1l_green_n_out(lamp_n), .lamp_drive_level_out(lvl),
    .lamp_drive_oe_out(oe));
  fpld_lamp_model lamps (.level_in(lvl), .oe_in(oe), .lit_out(lit));
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (exp !== got) begin
      failures++;
      $display("CHECK FAILED %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One request pulse, optionally retriggered inside the hold
  task automatic fire(int i, int w, int g);
    int t;
    exp_q.push_back(i * 256 + (g ? g + HOLD : w + HOLD - 1));
    req[i] = 1'b1;
    tick(w);
    req[i] = 1'b0;
    if (g) begin
      tick(g - w);
      req[i] = 1'b1;
      tick(1);
      req[i] = 1'b0;
    end
    for (t = 0; t < 200 && exp_q.size() > 0; t++) tick(1);
    if (exp_q.size() > 0) begin
      failures++;
      wrap_up();
    end
  endtask
  // Lit run length and lamp place, sampled mid-cycle where settled
  always @(negedge clk) begin
    if (|lit) begin
      cnt++;
      idx = $clog2(lit);
    end else if (cnt > 0) begin
      check("lit run", exp_q.size() ? exp_q.pop_front() : -1, idx*256+cnt);
      check("drive level", 0, lvl);
      cnt = 0;
    end
  end
  initial begin
    int w;
    int g;
    void'($urandom(57027));
    tick(16);
    rst_n = 1;
    for (int i = 0; i < 10; i++) begin
      w = $urandom_range(4, 1);
      g = $urandom_range(1, 0) ? w + $urandom_range(10, 1) : 0;
      fire(i, w, g);
    end
    pg = 1;
    tick(4);
    check("power lamp", 0, lamp_n);
    pg = 0;
    tick(4);
    check("power lamp", 1, lamp_n);
    wrap_up();
  end
endmodule
